//--- include/rws_pkg.sv
// Function
// - key-wipe bit erases the stored AES key
// - key-gen bit fills key from random words
// - irq high while enable and ready both set
// - data read clears ready, starts next word
// - ready reads zero while word in progress
// - finished word loads data, sets ready, unless key-gen bit is set
// - every apb register resets to zero, reserved reads zero
package rws_pkg;

    // bus and data geometry
    localparam int          RWS_ADDR_W    = 12;
    localparam int          RWS_DATA_W    = 32;
    localparam int          RWS_KEY_WORDS = 8;
    localparam int          RWS_KEY_W     = RWS_DATA_W * RWS_KEY_WORDS;
    localparam int          RWS_IDX_W     = $clog2(RWS_KEY_WORDS);
    localparam int          RWS_EVT_W     = 3;

    // register byte offsets
    localparam logic [11:0] RWS_OFS_CTRL  = 12'h000;
    localparam logic [11:0] RWS_OFS_STAT  = 12'h004;
    localparam logic [11:0] RWS_OFS_DATA  = 12'h008;
    localparam logic [11:0] RWS_OFS_EVT   = 12'h00C;
    localparam logic [11:0] RWS_OFS_MASK  = 12'h010;

    // control and status field positions
    localparam int          RWS_CTRL_WIPE = 15;
    localparam int          RWS_CTRL_KGEN = 3;
    localparam int          RWS_CTRL_IE   = 1;
    localparam int          RWS_STAT_RDY  = 0;

    // event bit positions
    localparam int          RWS_EVT_WORD  = 0;
    localparam int          RWS_EVT_KEY   = 1;
    localparam int          RWS_EVT_WIPE  = 2;

    // reset values and noise polynomial
    localparam logic [31:0] RWS_ZERO_W    = 32'h0000_0000;
    localparam logic [31:0] RWS_LFSR_SEED = 32'h0000_0001;
    localparam logic [31:0] RWS_LFSR_POLY = 32'h8020_0003;

    // register index decoded from the address
    typedef enum logic [2:0] {
        RWS_R_CTRL, RWS_R_STAT, RWS_R_DATA, RWS_R_EVT, RWS_R_MASK, RWS_R_NONE
    } rws_reg_t;

    // word engine states, gray along gen -> ready -> key
    typedef enum logic [1:0] {
        RWS_ST_GEN = 2'b00,
        RWS_ST_RDY = 2'b01,
        RWS_ST_KEY = 2'b11
    } rws_st_t;

    // state of the entropy collector
    typedef struct packed {
        logic [31:0] lfsr;
        logic [31:0] shift;
        logic [31:0] word;
        logic [5:0]  cnt;
        logic        busy;
        logic        done;
    } rws_ent_t;

    // state of the register block and sequencer
    typedef struct packed {
        rws_st_t                st;
        logic                   ie;
        logic                   kgen;
        logic                   wipe;
        logic [31:0]            data;
        logic [RWS_KEY_W-1:0]   key;
        logic [RWS_IDX_W-1:0]   idx;
        logic [RWS_EVT_W-1:0]   evt;
        logic [RWS_EVT_W-1:0]   mask;
        logic [31:0]            prdata;
        logic                   pslverr;
        logic                   start;
    } rws_state_t;

    // one step of the galois lfsr
    function automatic logic [31:0] rws_lfsr_step(input logic [31:0] v);
        return (v >> 1) ^ (v[0] ? RWS_LFSR_POLY : RWS_ZERO_W);
    endfunction : rws_lfsr_step

    // map a byte address onto a register index
    function automatic rws_reg_t rws_decode(input logic [RWS_ADDR_W-1:0] a);
        case (a)
            RWS_OFS_CTRL: return RWS_R_CTRL;
            RWS_OFS_STAT: return RWS_R_STAT;
            RWS_OFS_DATA: return RWS_R_DATA;
            RWS_OFS_EVT:  return RWS_R_EVT;
            RWS_OFS_MASK: return RWS_R_MASK;
            default:      return RWS_R_NONE;
        endcase
    endfunction : rws_decode

endpackage : rws_pkg

//--- src/rws_entropy.sv
`timescale 1ns/1ps
// collects one bit per enabled cycle while busy into a word
module rws_entropy
    import rws_pkg::*;
#(
    parameter int WORD_W = RWS_DATA_W
) (
    // clock, reset and enable
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    // raw noise and request
    input  wire logic              noise_in,
    input  wire logic              start,
    // finished word
    output logic                   busy,
    output logic                   done,
    output logic [RWS_DATA_W-1:0]  word
);

    localparam logic [5:0] LAST_BIT = 6'(WORD_W - 1);

    rws_ent_t s_q;   // registered state
    rws_ent_t s_d;   // next state

    // step the lfsr freely and gather bits while busy
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        s_d.lfsr = rws_lfsr_step(s_q.lfsr);
        if (start && !s_q.busy) begin
            // a fresh word always starts from an empty count
            s_d.busy = 1'b1;
            s_d.cnt  = '0;
        end else if (s_q.busy) begin
            // noise is mixed with the lfsr so a stuck pin still varies
            s_d.shift = {s_q.shift[30:0], s_q.lfsr[31] ^ noise_in};
            s_d.cnt   = s_q.cnt + 6'd1;
            if (s_q.cnt == LAST_BIT) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.word = {s_q.shift[30:0], s_q.lfsr[31] ^ noise_in};
            end
        end
    end

    // busy from reset so the first word needs no request
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{lfsr: RWS_LFSR_SEED, shift: RWS_ZERO_W, word: RWS_ZERO_W,
                     cnt: 6'd0, busy: 1'b1, done: 1'b0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;
    assign word = s_q.word;

endmodule : rws_entropy

//--- src/rws_top.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
// random word source with apb registers and key sequencer
module rws_top
    import rws_pkg::*;
(
    // clock, reset, enable
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    input  wire logic                   ce,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [RWS_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    // noise source
    input  wire logic                   noise_in,
    // key store and interrupt
    output logic [RWS_KEY_W-1:0]        aes_key,
    output logic                        irq
);

    localparam logic [RWS_IDX_W-1:0] LAST_IDX = RWS_IDX_W'(RWS_KEY_WORDS - 1);

    rws_state_t s_q;        // registered state
    rws_state_t s_d;        // next state
    logic       ent_busy;   // collector is gathering bits
    logic       ent_done;   // one-cycle word finished pulse
    logic [31:0] ent_word;  // last finished word
    logic       setup;      // apb setup phase
    logic       access;     // apb access phase, answered at once while ce is high
    rws_reg_t   rsel;       // decoded register

    // the collector that feeds both the data register and the key
    rws_entropy #(
        .WORD_W   (RWS_DATA_W)
    ) u_entropy (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ce       (ce),
        .noise_in (noise_in),
        .start    (s_q.start),
        .busy     (ent_busy),
        .done     (ent_done),
        .word     (ent_word)
    );

    // apb phase decode; a frozen block must not complete transfers
    assign setup  = psel && !penable;
    assign access = ce && psel && penable;
    assign rsel   = rws_decode(paddr);

    // read value of each register; reserved bits are zero
    function automatic logic [31:0] read_mux(input rws_reg_t r, input rws_state_t s);
        logic [31:0] v;
        v = RWS_ZERO_W;
        case (r)
            RWS_R_CTRL: begin
                v[RWS_CTRL_WIPE] = s.wipe;
                v[RWS_CTRL_KGEN] = s.kgen;
                v[RWS_CTRL_IE]   = s.ie;
            end
            RWS_R_STAT: begin
                // ready only in the ready state
                v[RWS_STAT_RDY] = (s.st == RWS_ST_RDY);
            end
            RWS_R_DATA: v = s.data;
            RWS_R_EVT:  v[RWS_EVT_W-1:0] = s.evt;
            RWS_R_MASK: v[RWS_EVT_W-1:0] = s.mask;
            default:    v = RWS_ZERO_W;
        endcase
        return v;
    endfunction : read_mux

    // next-state logic for registers, sequencer and key store
    always_comb begin
        logic [RWS_EVT_W-1:0] ev_set;   // hardware event pulses
        logic [RWS_EVT_W-1:0] ev_clr;   // software write-one clears
        ev_set    = '0;
        ev_clr    = '0;
        s_d       = s_q;
        s_d.start = 1'b0;

        // read data is captured in setup so prdata comes from a flop
        if (setup) begin
            s_d.prdata  = read_mux(rsel, s_q);
            s_d.pslverr = (rsel == RWS_R_NONE);
        end

        // register writes take effect at the access edge only
        if (access && pwrite) begin
            case (rsel)
                RWS_R_CTRL: begin
                    s_d.ie   = pwdata[RWS_CTRL_IE];
                    s_d.kgen = pwdata[RWS_CTRL_KGEN];
                    s_d.wipe = pwdata[RWS_CTRL_WIPE];
                end
                RWS_R_EVT:  ev_clr   = pwdata[RWS_EVT_W-1:0];
                RWS_R_MASK: s_d.mask = pwdata[RWS_EVT_W-1:0];
                default: begin
                    // read-only and unmapped words ignore writes
                end
            endcase
        end

        // word sequencer
        case (s_q.st)
            RWS_ST_GEN: begin
                if (s_q.kgen) begin
                    // word in flight becomes the first key word
                    s_d.st    = RWS_ST_KEY;
                    s_d.idx   = '0;
                    // a word finishing right now would be lost, so restart
                    s_d.start = !ent_busy;
                end else if (ent_done) begin
                    // new word lands and ready rises
                    s_d.data = ent_word;
                    s_d.st   = RWS_ST_RDY;
                    ev_set[RWS_EVT_WORD] = 1'b1;
                end
            end
            RWS_ST_RDY: begin
                if (s_q.kgen) begin
                    // collector is idle here, so kick it for the key
                    s_d.st    = RWS_ST_KEY;
                    s_d.idx   = '0;
                    s_d.start = 1'b1;
                end else if (access && !pwrite && rsel == RWS_R_DATA) begin
                    // reading the word drops ready and starts another
                    s_d.st    = RWS_ST_GEN;
                    s_d.start = 1'b1;
                end
            end
            RWS_ST_KEY: begin
                if (!s_q.kgen) begin
                    // software cancelled the key; resume plain words
                    s_d.st    = RWS_ST_GEN;
                    s_d.start = !ent_busy;
                end else if (ent_done) begin
                    // each finished word fills one key slot
                    s_d.key[s_q.idx*RWS_DATA_W +: RWS_DATA_W] = ent_word;
                    s_d.idx   = s_q.idx + 1'b1;
                    s_d.start = 1'b1;
                    if (s_q.idx == LAST_IDX) begin
                        s_d.kgen = 1'b0;
                        s_d.st   = RWS_ST_GEN;
                        ev_set[RWS_EVT_KEY] = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st    = RWS_ST_GEN;
                s_d.start = 1'b1;
            end
        endcase

        // wipe beats any key fill in the same cycle
        if (s_q.wipe) begin
            s_d.key  = '0;
            s_d.wipe = 1'b0;
            s_d.kgen = 1'b0;
            ev_set[RWS_EVT_WIPE] = 1'b1;
            if (s_q.st == RWS_ST_KEY) begin
                s_d.st    = RWS_ST_GEN;
                s_d.start = !ent_busy;
            end
        end

        // sticky events: a set in the clearing cycle survives
        s_d.evt = (s_q.evt & ~ev_clr) | ev_set;
    end

    // single state register, frozen while ce is low
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '{st: RWS_ST_GEN, ie: 1'b0, kgen: 1'b0, wipe: 1'b0,
                     data: RWS_ZERO_W, key: '0, idx: '0, evt: '0, mask: '0,
                     prdata: RWS_ZERO_W, pslverr: 1'b0, start: 1'b0};
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // outputs
    assign prdata  = s_q.prdata;
    assign pslverr = s_q.pslverr;
    assign pready  = access;
    assign aes_key = s_q.key;
    // enable gates everything, so with it clear no interrupt
    assign irq     = s_q.ie && ((s_q.st == RWS_ST_RDY) || |(s_q.evt & s_q.mask));

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    // a completed read of the data word while it is ready
    sequence data_read_s;
        ce && psel && penable && !pwrite && rsel == RWS_R_DATA
            && s_q.st == RWS_ST_RDY && !s_q.kgen;
    endsequence

    // a status read set up while no word is ready
    sequence stat_busy_s;
        ce && setup && rsel == RWS_R_STAT && s_q.st != RWS_ST_RDY;
    endsequence

    irq_ready_a: assert property (
        s_q.ie && s_q.st == RWS_ST_RDY |-> irq)
        else $error("ready word with enable set but no irq");

    irq_off_a: assert property (
        !s_q.ie |-> !irq)
        else $error("irq raised while enable is clear");

    read_clear_a: assert property (
        data_read_s |=> s_q.st == RWS_ST_GEN && s_q.start ##1 ent_busy)
        else $error("data read did not clear ready and restart");

    busy_status_a: assert property (
        stat_busy_s |=> s_q.prdata[RWS_STAT_RDY] == 1'b0)
        else $error("status shows ready during generation");

    data_update_a: assert property (
        ce && ent_done && s_q.st == RWS_ST_GEN && !s_q.kgen
        |=> s_q.st == RWS_ST_RDY && s_q.data == $past(ent_word))
        else $error("finished word not loaded into data");

    wipe_key_a: assert property (
        ce && s_q.wipe |=> s_q.key == '0 && !s_q.wipe && s_q.evt[RWS_EVT_WIPE])
        else $error("key not erased after wipe request");

    keygen_done_a: assert property (
        ce && s_q.st == RWS_ST_KEY && s_q.kgen && ent_done && !s_q.wipe
            && s_q.idx == LAST_IDX
        |=> !s_q.kgen && s_q.evt[RWS_EVT_KEY]
            && s_q.key[LAST_IDX*RWS_DATA_W +: RWS_DATA_W] == $past(ent_word))
        else $error("key generation did not finish on last word");

    reserved_zero_a: assert property (
        ce && setup && rsel == RWS_R_CTRL
        |=> (s_q.prdata & ~32'h0000_800A) == RWS_ZERO_W)
        else $error("reserved control bits read nonzero");

    first_word_a: assert property (
        !$past(rstn) |-> s_q.st == RWS_ST_GEN && ent_busy && s_q.data == RWS_ZERO_W)
        else $error("generation not running right after reset");

    unmapped_err_a: assert property (
        ce && setup && rsel == RWS_R_NONE |=> pslverr && prdata == RWS_ZERO_W)
        else $error("unmapped address not flagged");

    // an event clear written by software in this cycle
    sequence evt_clear_s;
        access && pwrite && rsel == RWS_R_EVT;
    endsequence

    // a status read set up while a word is ready
    sequence stat_ready_s;
        ce && setup && rsel == RWS_R_STAT && s_q.st == RWS_ST_RDY;
    endsequence

    // unmasked events also drive the line while enabled
    irq_event_a: assert property (
        s_q.ie && |(s_q.evt & s_q.mask) |-> irq)
        else $error("unmasked event with enable set but no irq");

    // nothing ready and nothing unmasked keeps the line low
    irq_quiet_a: assert property (
        s_q.st != RWS_ST_RDY && (s_q.evt & s_q.mask) == '0 |-> !irq)
        else $error("irq raised with no cause");

    // an event stays set until software writes it away
    evt_sticky_a: assert property (
        s_q.evt[RWS_EVT_WORD] && !(access && pwrite && rsel == RWS_R_EVT)
        |=> s_q.evt[RWS_EVT_WORD])
        else $error("word event lost without a clear");

    // a one written to an event bit clears it when nothing sets it again
    evt_clear_a: assert property (
        evt_clear_s ##0 (pwdata[RWS_EVT_WIPE] && !s_q.wipe)
        |=> !s_q.evt[RWS_EVT_WIPE])
        else $error("wipe event not cleared by write one");

    // the enable bit lands exactly as written
    ctrl_write_a: assert property (
        access && pwrite && rsel == RWS_R_CTRL |=> s_q.ie == $past(pwdata[RWS_CTRL_IE]))
        else $error("enable bit not stored");

    // a status read during ready shows the flag
    ready_stat_a: assert property (
        stat_ready_s |=> s_q.prdata[RWS_STAT_RDY])
        else $error("status misses ready flag");

    // the data word only moves when a finished word lands
    data_hold_a: assert property (
        !ent_done |=> $stable(s_q.data))
        else $error("data word changed without a finished word");

    // ready never rises without a finished word
    no_early_rdy_a: assert property (
        ce && s_q.st == RWS_ST_GEN && !ent_done |=> s_q.st != RWS_ST_RDY)
        else $error("ready rose while a word was in progress");

    // key fill never shows a ready word
    key_no_rdy_a: assert property (
        s_q.st == RWS_ST_KEY |=> s_q.st != RWS_ST_RDY)
        else $error("ready shown during key generation");

    // reserved status bits read as zero
    stat_reserved_a: assert property (
        ce && setup && rsel == RWS_R_STAT
        |=> s_q.prdata[RWS_DATA_W-1:RWS_STAT_RDY+1] == '0)
        else $error("reserved status bits read nonzero");

    // writes to unmapped words change no setting
    unmapped_wr_a: assert property (
        access && pwrite && rsel == RWS_R_NONE
        |=> $stable(s_q.ie) && $stable(s_q.mask))
        else $error("unmapped write changed a setting");

    // a low enable freezes every register
    ce_freeze_a: assert property (
        !ce |=> $stable(s_q))
        else $error("state moved while enable was low");

    // a start pulse always wakes an idle collector
    start_kick_a: assert property (
        ce && s_q.start && !ent_busy |=> ent_busy)
        else $error("collector ignored a start pulse");

    // each finished key word advances the slot index
    key_step_a: assert property (
        ce && s_q.st == RWS_ST_KEY && s_q.kgen && ent_done && !s_q.wipe
            && s_q.idx != LAST_IDX
        |=> s_q.st == RWS_ST_KEY && s_q.idx == $past(s_q.idx) + 1'b1)
        else $error("key slot index did not advance");

    // an erased key stays erased outside key generation
    key_hold_a: assert property (
        s_q.key == '0 && s_q.st != RWS_ST_KEY |=> s_q.key == '0)
        else $error("erased key changed outside generation");

endmodule : rws_top

//--- test/tb_random_word_source.sv
`timescale 1ns/1ps
// self-checking bench: register table, word flow, interrupt, key sequencer, reset
module tb_random_word_source
    import rws_pkg::*;
();
    // one register access and what it should give back
    typedef struct packed {
        logic        wr;
        logic [11:0] a;
        logic [31:0] wd;
        logic [31:0] exp;
        logic        err;
    } rws_row_t;

    // clock, reset, enable
    logic                  sys_clk = 1'b0;
    logic                  rstn    = 1'b0;
    logic                  ce      = 1'b1;
    // apb master side
    logic                  psel    = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite  = 1'b0;
    logic [RWS_ADDR_W-1:0] paddr   = 12'h000;
    logic [31:0]           pwdata  = 32'h0000_0000;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    // noise, key, interrupt
    logic                  noise_in  = 1'b0;
    logic [7:0]            noise_cnt = 8'h00;
    logic [RWS_KEY_W-1:0]  aes_key;
    logic                  irq;
    // bookkeeping
    int                    mismatches = 0;
    int                    num_checks = 0;
    logic [31:0]           rd;
    logic [31:0]           d1;
    logic                  er;

    // reserved bits are set on purpose: they must read back as zero
    localparam rws_row_t ROWS [12] = '{
        '{1'b0, RWS_OFS_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, RWS_OFS_STAT, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, RWS_OFS_DATA, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, RWS_OFS_EVT,  32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, RWS_OFS_MASK, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, RWS_OFS_CTRL, 32'hFFFF_7FF5, 32'h0000_0000, 1'b0},
        '{1'b0, RWS_OFS_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, RWS_OFS_MASK, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0},
        '{1'b0, RWS_OFS_MASK, 32'h0000_0000, 32'h0000_0007, 1'b0},
        '{1'b1, RWS_OFS_MASK, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 12'h018,      32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b1, 12'h014,      32'hFFFF_FFFF, 32'h0000_0000, 1'b1}
    };

    // design under test
    rws_top u_dut (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ce       (ce),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .noise_in (noise_in),
        .aes_key  (aes_key),
        .irq      (irq)
    );

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // irregular noise so successive words differ
    always @(posedge sys_clk) begin
        noise_cnt <= noise_cnt + 8'h01;
        noise_in  <= noise_cnt[0] ^ noise_cnt[3] ^ noise_cnt[5];
    end

    // print the counts and the verdict, then stop
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // word compare
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk_w

    // flag compare
    task automatic chk_b(input logic got, input logic exp, input string m);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask : chk_b

    // one apb transfer, entered just after a rising edge; one idle cycle after it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: no apb answer", $time);
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb

    // poll one register bit until it reaches a value, bounded
    task automatic poll(input logic [11:0] a, input int b, input logic v, input string m);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0000_0000);
            n++;
        end while (rd[b] !== v && n < 200);
        chk_b(rd[b], v, m);
    endtask : poll

    // cut a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end

    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        foreach (ROWS[i]) begin
            apb(ROWS[i].wr, ROWS[i].a, ROWS[i].wd);
            if (!ROWS[i].wr) begin
                chk_w(rd, ROWS[i].exp, "register row");
            end
            chk_b(er, ROWS[i].err, "row error flag");
        end
        // first word appears unasked, no interrupt while enable is off
        poll(RWS_OFS_STAT, RWS_STAT_RDY, 1'b1, "first ready");
        chk_b(irq, 1'b0, "irq disabled");
        apb(1'b1, RWS_OFS_CTRL, 32'h0000_0002);
        chk_b(irq, 1'b1, "irq on ready");
        // reading the word drops ready and the interrupt
        apb(1'b0, RWS_OFS_DATA, 32'h0000_0000);
        d1 = rd;
        apb(1'b0, RWS_OFS_STAT, 32'h0000_0000);
        chk_w(rd, 32'h0000_0000, "ready after read");
        chk_b(irq, 1'b0, "irq masked event");
        // word event raises irq once unmasked, clears on write one
        apb(1'b1, RWS_OFS_MASK, 32'h0000_0001);
        chk_b(irq, 1'b1, "irq unmasked event");
        apb(1'b1, RWS_OFS_EVT, 32'h0000_0007);
        chk_b(irq, 1'b0, "irq after clear");
        apb(1'b0, RWS_OFS_EVT, 32'h0000_0000);
        chk_w(rd, 32'h0000_0000, "events cleared");
        // a fresh word follows the read
        poll(RWS_OFS_STAT, RWS_STAT_RDY, 1'b1, "next ready");
        apb(1'b0, RWS_OFS_DATA, 32'h0000_0000);
        chk_b(rd !== d1, 1'b1, "word changed");
        // key generation: bit self-clears when the key is full
        apb(1'b1, RWS_OFS_CTRL, 32'h0000_0008);
        poll(RWS_OFS_CTRL, RWS_CTRL_KGEN, 1'b0, "keygen done");
        chk_b(aes_key != '0, 1'b1, "key filled");
        apb(1'b0, RWS_OFS_EVT, 32'h0000_0000);
        chk_b(rd[RWS_EVT_KEY], 1'b1, "key event");
        // key wipe erases it and self-clears
        apb(1'b1, RWS_OFS_CTRL, 32'h0000_8000);
        apb(1'b0, RWS_OFS_CTRL, 32'h0000_0000);
        chk_w(rd, 32'h0000_0000, "wipe bit cleared");
        chk_b(aes_key == '0, 1'b1, "key wiped");
        // reset in mid-run, outputs and registers back at zero
        apb(1'b1, RWS_OFS_CTRL, 32'h0000_0002);
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk_b(irq, 1'b0, "irq in reset");
        chk_w(prdata, 32'h0000_0000, "prdata in reset");
        rstn <= 1'b1;
        // enable held low past one word time: status must stay clear
        ce   <= 1'b0;
        repeat (50) @(posedge sys_clk);
        ce   <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, ROWS[i].a, 32'h0000_0000);
            chk_w(rd, 32'h0000_0000, "after second reset");
        end
        close_out();
    end
endmodule : tb_random_word_source
